// File: pcn_negotiator.sv
// Negotiation phase controller: request issue, reply handling, contracts.
// Assumes a packet layer that sends tx_* packets and reports rx_* replies.
//
// Design decisions made here: the register addresses and the plain strobed port.
`include "pcn_params.svh"
module pcn_negotiator #(
    parameter int TIMEOUT_CYC = `PCN_TIMEOUT_CYC,
    parameter int SILENT_CYC = `PCN_SILENT_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic tx_valid,
    output logic [7:0] tx_header,
    output logic [7:0] tx_b0,
    output logic [7:0] tx_b1,
    input wire logic tx_done,
    input wire logic rx_valid,
    input wire logic rx_is_response,
    input wire logic [7:0] rx_byte,
    output logic calibration_go
);
    import pcn_pkg::*;

    pcn_state_t state;
    pcn_contract_t active;
    pcn_contract_t temp;
    logic [7:0] p_hdr;
    logic [7:0] p_b0;
    logic [7:0] p_b1;
    logic [1:0] retries;
    logic [31:0] timer;
    logic [2:0] last_rsp;
    logic unsupported;
    logic rpfmt_sent;
    logic [7:0] rx_data;
    logic copied;

    // Command word: [7:0] header, [15:8] byte0, [23:16] byte1
    wire cmd_wr = reg_wr && reg_addr == `PCN_ADR_CMD && state == PCN_IDLE;
    wire [7:0] c_hdr = reg_wdata[7:0];
    wire [7:0] c_b0 = reg_wdata[15:8];
    wire [7:0] c_b1 = reg_wdata[23:16];
    wire is_spec = p_hdr == `PCN_HDR_SPECIFIC;
    wire is_gen = p_hdr == `PCN_HDR_GENERAL;
    wire is_end = is_spec && p_b0 == `PCN_REQ_END;
    wire [2:0] diff_cnt = 3'((active.gpow != temp.gpow))
        + 3'((active.mpow != temp.mpow))
        + 3'((active.rpfmt != temp.rpfmt))
        + 3'((active.fsk != temp.fsk))
        + 3'((active.prop != temp.prop));
    wire c_rpfmt = c_hdr == `PCN_HDR_SPECIFIC && c_b0 == `PCN_REQ_RPFMT;
    wire [7:0] c_b1_fix = c_rpfmt ? `PCN_HDR_RP24 : c_b1;
    // End refused until format request was sent
    wire c_end = c_hdr == `PCN_HDR_SPECIFIC && c_b0 == `PCN_REQ_END;
    wire c_ok = !(c_end && !rpfmt_sent);
    wire [7:0] c_b1_out = c_end ? {5'h00, diff_cnt} : c_b1_fix;
    wire reply = state == PCN_WAIT && rx_valid;
    wire rsp_ack = reply && rx_is_response && rx_byte == `PCN_RSP_ACK;
    wire rsp_nak = reply && rx_is_response && rx_byte == `PCN_RSP_NAK;
    wire rsp_undef = reply && rx_is_response && rx_byte == `PCN_RSP_UNDEF;
    wire timed_out = state == PCN_WAIT && !rx_valid && timer == 32'h0;
    wire give_up = timed_out && retries == `PCN_MAX_RETRY;
    wire [31:0] stat_word = {12'h000, rx_data, 1'b0, copied,
        rpfmt_sent, unsupported, last_rsp[2:0], 5'(state)};
    // Contract words show the four named fields; proprietary sits apart
    wire [31:0] next_rdata = (reg_addr == `PCN_ADR_CMD) ?
            {8'h00, p_b1, p_b0, p_hdr} :
        (reg_addr == `PCN_ADR_STAT) ? stat_word :
        (reg_addr == `PCN_ADR_ACT0) ? active[39:8] :
        (reg_addr == `PCN_ADR_TMP0) ? temp[39:8] :
        (reg_addr == `PCN_ADR_DATA) ? {active.prop, temp.prop, 16'h0000} :
        32'h0000_0000;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= PCN_IDLE;
            p_hdr <= 8'h00;
            p_b0 <= 8'h00;
            p_b1 <= 8'h00;
            retries <= 2'h0;
            timer <= 32'h0;
            last_rsp <= 3'h0;
            unsupported <= 1'b0;
            rpfmt_sent <= 1'b0;
            rx_data <= 8'h00;
            copied <= 1'b0;
            tx_valid <= 1'b0;
            tx_header <= 8'h00;
            tx_b0 <= 8'h00;
            tx_b1 <= 8'h00;
            calibration_go <= 1'b0;
            active <= '{`PCN_GP_INIT, 8'h00, `PCN_HDR_RP8, 8'h00, 8'h00};
            temp <= '{`PCN_GP_INIT, 8'h00, `PCN_HDR_RP8, 8'h00, 8'h00};
        end else begin
            case (state)
                PCN_IDLE: begin
                    // Active contract may be preloaded while idle, until the first request copies it
                    if (reg_wr && reg_addr == `PCN_ADR_ACT0 && !copied) begin
                        active[39:8] <= reg_wdata;
                    end
                    // Any header is passed; other types get no reply wait
                    if (cmd_wr && c_ok) begin
                        // Copy active contract before first request
                        if (!copied) begin
                            temp <= active;
                            copied <= 1'b1;
                        end
                        p_hdr <= c_hdr;
                        p_b0 <= c_b0;
                        p_b1 <= c_b1_out;
                        tx_header <= c_hdr;
                        tx_b0 <= c_b0;
                        tx_b1 <= c_b1_out;
                        tx_valid <= 1'b1;
                        retries <= 2'h0;
                        unsupported <= 1'b0;
                        if (c_rpfmt) begin
                            rpfmt_sent <= 1'b1;
                        end
                        state <= PCN_SEND;
                    end
                end
                PCN_SEND: begin
                    if (tx_done) begin
                        tx_valid <= 1'b0;
                        timer <= TIMEOUT_CYC - 1;
                        // Non negotiation packets expect no reply
                        state <= (is_spec || is_gen) ? PCN_WAIT : PCN_SILENT;
                        if (!(is_spec || is_gen)) begin
                            timer <= SILENT_CYC - 1;
                        end
                    end
                end
                PCN_WAIT: begin
                    // Reply belongs to the one pending request
                    if (reply) begin
                        timer <= SILENT_CYC - 1;
                        state <= PCN_SILENT;
                        last_rsp <= {rsp_undef, rsp_nak, rsp_ack};
                        if (!rx_is_response) begin
                            rx_data <= rx_byte;
                        end
                        if (rsp_undef) begin
                            unsupported <= 1'b1;
                        end
                        if (rsp_ack && is_spec) begin
                            if (p_b0 == `PCN_REQ_GPOW) temp.gpow <= p_b1;
                            if (p_b0 == `PCN_REQ_RPFMT) temp.rpfmt <= p_b1;
                            if (p_b0 == `PCN_REQ_FSK) temp.fsk <= p_b1;
                            if (p_b0 == `PCN_REQ_MPOW) temp.mpow <= p_b1;
                            if (p_b0 >= `PCN_REQ_PROP) temp.prop <= p_b1;
                        end
                        if (rsp_ack && is_end) begin
                            active <= temp;
                            state <= PCN_DONE;
                        end
                        if (rsp_nak && is_end) begin
                            temp <= active;
                        end
                    end else if (give_up) begin
                        unsupported <= 1'b1;
                        timer <= SILENT_CYC - 1;
                        state <= PCN_SILENT;
                    end else if (timed_out) begin
                        retries <= retries + 2'h1;
                        tx_valid <= 1'b1;
                        state <= PCN_SEND;
                    end else begin
                        timer <= timer - 32'h1;
                    end
                end
                PCN_SILENT: begin
                    // Gap keeps the next request clear of the last reply
                    if (timer == 32'h0) begin
                        state <= PCN_IDLE;
                    end else begin
                        timer <= timer - 32'h1;
                    end
                end
                PCN_DONE: begin
                    calibration_go <= 1'b1;
                end
                default: begin
                    state <= PCN_IDLE;
                end
            endcase
        end
    end

    a_end_commit: assert property (
        @(posedge mclk) disable iff (!rst_n)
        rsp_ack && is_end |=> active == $past(temp))
        else $error("active not committed");
    a_end_discard: assert property (
        @(posedge mclk) disable iff (!rst_n)
        rsp_nak && is_end |=> temp == $past(active))
        else $error("temp not restored");
    a_calib_go: assert property (
        @(posedge mclk) disable iff (!rst_n)
        rsp_ack && is_end |=> ##1 calibration_go)
        else $error("no calibration");
    a_undef_keep: assert property (
        @(posedge mclk) disable iff (!rst_n)
        rsp_undef |=> temp == $past(temp) && unsupported)
        else $error("undefined reply changed contract");
    a_rp_header: assert property (
        @(posedge mclk) disable iff (!rst_n)
        tx_valid && tx_header == `PCN_HDR_SPECIFIC
        && tx_b0 == `PCN_REQ_RPFMT |-> tx_b1 == `PCN_HDR_RP24)
        else $error("bad format header");
    a_end_order: assert property (
        @(posedge mclk) disable iff (!rst_n)
        tx_valid && tx_header == `PCN_HDR_SPECIFIC
        && tx_b0 == `PCN_REQ_END |-> rpfmt_sent)
        else $error("end before format");
    a_gp_temp: assert property (
        @(posedge mclk) disable iff (!rst_n)
        rsp_ack && is_spec && p_b0 == `PCN_REQ_GPOW
        |=> temp.gpow == $past(p_b1) && active == $past(active))
        else $error("gpow store wrong");
    // Wait is left only after reply or timeout
    a_one_pending: assert property (
        @(posedge mclk) disable iff (!rst_n)
        state == PCN_WAIT && !rx_valid && timer != 32'h0
        |=> state == PCN_WAIT)
        else $error("left wait early");
    a_retry_max: assert property (
        @(posedge mclk) disable iff (!rst_n)
        give_up |=> state == PCN_SILENT && unsupported)
        else $error("retry handling");
    a_copy_first: assert property (
        @(posedge mclk) disable iff (!rst_n)
        cmd_wr && c_ok && !copied |=> temp == $past(active) && copied)
        else $error("contract not copied");
    // Format ACK stores 24 bit format
    a_fmt_temp: assert property (
        @(posedge mclk) disable iff (!rst_n)
        rsp_ack && is_spec && p_b0 == `PCN_REQ_RPFMT
        |=> temp.rpfmt == `PCN_HDR_RP24)
        else $error("format not stored");
    a_fsk_temp: assert property (
        @(posedge mclk) disable iff (!rst_n)
        rsp_ack && is_spec && p_b0 == `PCN_REQ_FSK
        |=> temp.fsk == $past(p_b1))
        else $error("modulation not stored");
    // Packet held until the layer ends it
    a_tx_hold: assert property (
        @(posedge mclk) disable iff (!rst_n)
        tx_valid && !tx_done |=> tx_valid && $stable(tx_header))
        else $error("packet dropped early");
endmodule : pcn_negotiator

// File: pcn_params.svh
// Constants for the power contract negotiation controller.
// Assumes a 50 MHz mclk and an outside packet layer that frames packets.
`ifndef PCN_PARAMS_SVH
`define PCN_PARAMS_SVH
`define PCN_CLK_MHZ 50
`define PCN_TIMEOUT_US 15000
`define PCN_TIMEOUT_CYC (`PCN_TIMEOUT_US * `PCN_CLK_MHZ)
`define PCN_SILENT_US 6000
`define PCN_SILENT_CYC (`PCN_SILENT_US * `PCN_CLK_MHZ)
`define PCN_MAX_RETRY 2'h3
`define PCN_HDR_SPECIFIC 8'h20
`define PCN_HDR_GENERAL 8'h07
`define PCN_HDR_EPT 8'h02
`define PCN_HDR_RP24 8'h31
`define PCN_HDR_RP8 8'h04
`define PCN_EPT_NEG_FAIL 8'h0A
`define PCN_REQ_END 8'h00
`define PCN_REQ_GPOW 8'h01
`define PCN_REQ_RPFMT 8'h02
`define PCN_REQ_FSK 8'h03
`define PCN_REQ_MPOW 8'h04
`define PCN_REQ_PROP 8'hF0
`define PCN_GP_INIT 8'h0A
`define PCN_RSP_ACK 8'hFF
`define PCN_RSP_NAK 8'h00
`define PCN_RSP_UNDEF 8'h55
`define PCN_ADR_CMD 4'h0
`define PCN_ADR_STAT 4'h1
`define PCN_ADR_ACT0 4'h2
`define PCN_ADR_TMP0 4'h3
`define PCN_ADR_DATA 4'h4
`endif

// File: pcn_pkg.sv
// Types for the power contract negotiation controller.
// Assumes nothing beyond the constants header.
package pcn_pkg;
    typedef enum logic [4:0] {
        PCN_IDLE = 5'h01,
        PCN_SEND = 5'h02,
        PCN_WAIT = 5'h04,
        PCN_SILENT = 5'h08,
        PCN_DONE = 5'h10
    } pcn_state_t;
    typedef struct packed {
        logic [7:0] gpow;
        logic [7:0] mpow;
        logic [7:0] rpfmt;
        logic [7:0] fsk;
        logic [7:0] prop;
    } pcn_contract_t;
endpackage : pcn_pkg

// File: pcn_tx_model.sv
// Transmitter stand-in: closes each packet, then answers as configured.
// Assumes the bench sets rsp_en and rsp_code before each request.
module pcn_tx_model (
    input wire logic mclk,
    input wire logic tx_valid,
    input wire logic [7:0] tx_header,
    input wire logic rsp_en,
    input wire logic [7:0] rsp_code,
    input wire logic [7:0] data_byte,
    output logic tx_done,
    output logic rx_valid,
    output logic rx_is_response,
    output logic [7:0] rx_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        logic [7:0] hdr;
        tx_done = 1'b0;
        rx_valid = 1'b0;
        rx_is_response = 1'b0;
        rx_byte = 8'hA5;
        forever begin
            @(posedge mclk);
            // Idle line toggles so a stale byte never looks valid
            rx_byte <= ~rx_byte;
            if (tx_valid === 1'b1) begin
                hdr = tx_header;
                repeat (3) @(posedge mclk);
                tx_done <= 1'b1;
                @(posedge mclk);
                tx_done <= 1'b0;
                repeat (4) @(posedge mclk);
                if (rsp_en) begin
                    rx_valid <= 1'b1;
                    rx_is_response <= (hdr != 8'h07);
                    rx_byte <= (hdr == 8'h07) ? data_byte : rsp_code;
                    @(posedge mclk);
                    rx_valid <= 1'b0;
                end
            end
        end
    end
endmodule : pcn_tx_model

// File: power_contract_negotiation_test.sv
// Bench for the negotiation controller against a transmitter stand-in.
// Assumes short timeout and silent counts so the run stays brief.
module power_contract_negotiation_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] all_ones = 32'hFFFFFFFF;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic tx_valid, tx_done, rx_valid, rx_is_response, calibration_go;
    logic [7:0] tx_header, tx_b0, tx_b1, rx_byte;
    logic rsp_en = 1'b0;
    logic [7:0] rsp_code = 8'h00;
    logic [7:0] data_byte = 8'h00;
    logic tx_prev = 1'b0;
    logic rd_pend = 1'b0;
    logic [31:0] rd_last = 32'h0;
    logic [23:0] tx_q[$];
    logic [63:0] rd_q[$];
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;
    int seed = 32'hfa318d67;
    logic [7:0] f, p;
    pcn_negotiator #(.TIMEOUT_CYC(20), .SILENT_CYC(5)) pcn_negotiator_i (
        .mclk(mclk),
        .rst_n(rst_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .tx_valid(tx_valid),
        .tx_header(tx_header),
        .tx_b0(tx_b0),
        .tx_b1(tx_b1),
        .tx_done(tx_done),
        .rx_valid(rx_valid),
        .rx_is_response(rx_is_response),
        .rx_byte(rx_byte),
        .calibration_go(calibration_go)
    );
    pcn_tx_model pcn_tx_model_i (
        .mclk(mclk),
        .tx_valid(tx_valid),
        .tx_header(tx_header),
        .rsp_en(rsp_en),
        .rsp_code(rsp_code),
        .data_byte(data_byte),
        .tx_done(tx_done),
        .rx_valid(rx_valid),
        .rx_is_response(rx_is_response),
        .rx_byte(rx_byte)
    );
    initial begin
        forever #10 mclk = ~mclk;
    end
    task automatic fail(input string m);
        miscompares++;
        $display("[FAIL] %0t %s", $time, m);
    endtask : fail
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    task automatic chk(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1) fail(m);
    endtask : chk
    // Watcher: each packet, and each read result with a nonzero mask, is checked against the oldest note
    always @(posedge mclk) begin
        logic [63:0] e;
        tx_prev <= tx_valid;
        rd_pend <= reg_rd;
        cycles++;
        if (cycles == 20000) begin
            fail("timeout");
            complete_run();
        end
        if (tx_valid === 1'b1 && tx_prev === 1'b0) begin
            total_checks++;
            if (tx_q.size() == 0) fail("unexpected packet");
            else if ({tx_header, tx_b0, tx_b1} !== tx_q.pop_front())
                fail("packet fields");
        end
        if (rd_pend === 1'b1) begin
            rd_last = reg_rdata;
            e = rd_q.pop_front();
            if (e[63:32] !== 32'h0) begin
                total_checks++;
                if ((reg_rdata & e[63:32]) !== e[31:0])
                    fail("read data");
            end
        end
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] m, x);
        rd_q.push_back({m, x & m});
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
        #1;
    endtask : rd
    // Bounded poll until idle or committed
    task automatic wait_idle();
        for (int i = 0; i < 300; i++) begin
            rd(4'h1, 32'h0, 32'h0);
            if (rd_last[4:0] === 5'h01 || rd_last[4:0] === 5'h10) return;
        end
        fail("no return to idle");
    endtask : wait_idle
    task automatic cmd(input logic [7:0] h, r, v, b, c,
                       input logic en, input int n);
        rsp_en <= en;
        rsp_code <= c;
        repeat (n) tx_q.push_back({h, r, b});
        wr(4'h0, {8'h00, v, r, h});
        wait_idle();
    endtask : cmd
    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        wr(4'h2, 32'h0A200411);
        rd(4'h2, all_ones, 32'h0A200411);
        cmd(8'h20, 8'h00, 8'h00, 8'h00, 8'hFF, 1'b1, 0);
        rd(4'h1, 32'h1F, 32'h01);
        cmd(8'h20, 8'h01, 8'h14, 8'h14, 8'hFF, 1'b1, 1);
        rd(4'h3, all_ones, 32'h14200411);
        rd(4'h2, all_ones, 32'h0A200411);
        rd(4'h1, 32'h4E0, 32'h420);
        f = 8'($random(seed));
        cmd(8'h20, 8'h02, f, 8'h31, 8'hFF, 1'b1, 1);
        f = {1'b1, f[6:0]};
        cmd(8'h20, 8'h03, f, f, 8'hFF, 1'b1, 1);
        cmd(8'h20, 8'h04, 8'h40, 8'h40, 8'h55, 1'b1, 1);
        rd(4'h3, all_ones, {16'h1420, 8'h31, f});
        rd(4'h1, 32'h2E0, 32'h280);
        p = 8'($random(seed)) | 8'h80;
        cmd(8'h20, 8'hF0, p, p, 8'hFF, 1'b1, 1);
        rd(4'h4, 32'h00FFFFFF, {8'h00, p, 16'h0000});
        cmd(8'h20, 8'h04, 8'h40, 8'h40, 8'h00, 1'b0, 4);
        rd(4'h1, 32'h100, 32'h100);
        f = 8'($random(seed));
        data_byte <= f;
        cmd(8'h07, 8'h30, 8'h00, 8'h00, 8'hFF, 1'b1, 1);
        rd(4'h1, 32'hFF000, {12'h0, f, 12'h0});
        cmd(8'h20, 8'h00, 8'h00, 8'h04, 8'h00, 1'b1, 1);
        rd(4'h3, all_ones, 32'h0A200411);
        cmd(8'h02, 8'h0A, 8'h00, 8'h00, 8'h00, 1'b0, 1);
        cmd(8'h20, 8'h01, 8'h14, 8'h14, 8'hFF, 1'b1, 1);
        cmd(8'h20, 8'h00, 8'h00, 8'h01, 8'hFF, 1'b1, 1);
        rd(4'h2, all_ones, 32'h14200411);
        chk(calibration_go, "calibration not entered");
        rd(4'h1, 32'h1F, 32'h10);
        rd(4'h5, all_ones, 32'h0);
        complete_run();
    end
endmodule : power_contract_negotiation_test
